// *** logic/pg_pkg.sv ***
// package: constants and carriers for the pin enable/disable guard
`default_nettype none
package pg_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CMD    = 8'h00;
	localparam logic [7:0] OFF_PIN    = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_SW     = 8'h0C;
	localparam logic [7:0] OFF_REF    = 8'h10;
	localparam logic [7:0] OFF_PUK    = 8'h14;
	localparam logic [7:0] OFF_TLV    = 8'h18;
	localparam logic [7:0] OFF_ALTK   = 8'h1C;
	// command codes in cmd register bits 2:0
	localparam logic [2:0] CMD_VERIFY  = 3'h1;
	localparam logic [2:0] CMD_DISABLE = 3'h2;
	localparam logic [2:0] CMD_ENABLE  = 3'h3;
	localparam logic [2:0] CMD_UNBLOCK = 3'h4;
	localparam logic [2:0] CMD_READ    = 3'h5;
	localparam logic [2:0] CMD_RESET   = 3'h6;
	localparam int CMD_EMPTY_BIT   = 8;
	localparam int CMD_PROT_BIT    = 9;
	localparam int CMD_ALT_BIT     = 10;
	// status words
	localparam logic [7:0] SW1_OK      = 8'h90;
	localparam logic [7:0] SW2_OK      = 8'h00;
	localparam logic [7:0] SW1_RETRY   = 8'h63;
	localparam logic [3:0] SW2_RETRY_H = 4'hC;
	localparam logic [7:0] SW1_REFUSE  = 8'h69;
	localparam logic [7:0] SW2_DENIED  = 8'h82;
	localparam logic [7:0] SW2_BLOCKED = 8'h83;
	localparam logic [7:0] SW2_NOTALLOW = 8'h85;
	// status template object
	localparam logic [7:0] TAG_FCP    = 8'h62;
	localparam logic [7:0] TAG_PS     = 8'hC6;
	localparam logic [7:0] TAG_USAGE  = 8'h90;
	localparam logic [7:0] PS_ENABLED = 8'h80;
	localparam logic [7:0] PS_DISABLED = 8'h00;
	// counter initial values
	localparam logic [3:0] PIN_TRIES_INIT = 4'h3;
	localparam logic [3:0] PUK_TRIES_INIT = 4'hA;
	localparam logic [31:0] PIN_RESET_VAL = 32'h0000_0000;
	localparam logic [31:0] PUK_RESET_VAL = 32'h1234_5678;

	typedef struct packed
	{
		logic [7:0] sw1;
		logic [7:0] sw2;
	} pg_sw_s;
endpackage : pg_pkg
`default_nettype wire

// *** logic/pg_guard.sv ***
// module: card-side pin enable/disable/verify/unblock guard behind apb
`default_nettype none
module pg_guard
(
	// apb clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// status to the file system
	output logic             pin_enabled,
	output logic             pin_blocked,
	output logic             access_granted
);
	typedef enum logic [2:0]
	{
		PG_IDLE = 3'b001,
		PG_EXEC = 3'b010,
		PG_DONE = 3'b100
	} pg_state_e;

	pg_state_e      state_q;
	logic [31:0]    cmd_q;
	logic [31:0]    pin_in_q;
	logic [31:0]    ref_q;
	logic [31:0]    puk_q;
	logic [3:0]     tries_q;
	logic [3:0]     puk_tries_q;
	logic           enabled_q;
	logic           verified_q;
	logic           alt_key_q;
	logic           busy_q;
	pg_pkg::pg_sw_s sw_q;
	pg_pkg::pg_sw_s sw_d;
	logic [3:0]     tries_d;
	logic [3:0]     puk_tries_d;
	logic           enabled_d;
	logic           verified_d;
	logic           alt_key_d;
	logic [31:0]    ref_d;

	logic wr;
	logic rd;
	logic start;
	logic blocked;
	logic puk_blocked;
	logic match;
	logic puk_match;
	logic [2:0] op;
	logic empty;

	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign start = wr && (paddr == pg_pkg::OFF_CMD) && !busy_q;
	assign blocked = (tries_q == 4'h0);
	assign puk_blocked = (puk_tries_q == 4'h0);
	assign match = (pin_in_q == ref_q);
	assign puk_match = (pin_in_q == puk_q);
	assign op = cmd_q[2:0];
	assign empty = cmd_q[pg_pkg::CMD_EMPTY_BIT];
	assign pin_enabled = enabled_q;
	assign pin_blocked = blocked;
	// blocked+enabled denies, blocked+disabled grants
	assign access_granted = !enabled_q || (verified_q && !blocked);

	// command sequencer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_q <= PG_IDLE;
		else
			unique case (state_q)
				PG_IDLE: if (start) state_q <= PG_EXEC;
				PG_EXEC: state_q <= PG_DONE;
				PG_DONE: state_q <= PG_IDLE;
				default: state_q <= PG_IDLE;
			endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			busy_q <= 1'b0;
		else if (start)
			busy_q <= 1'b1;
		else if (state_q == PG_DONE)
			busy_q <= 1'b0;
	end

	// command and pin operand registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cmd_q    <= 32'h0000_0000;
			pin_in_q <= 32'h0000_0000;
		end
		else
		begin
			if (start)
				cmd_q <= pwdata;
			if (wr && paddr == pg_pkg::OFF_PIN && !busy_q)
				pin_in_q <= pwdata;
		end
	end

	// command evaluation
	always_comb
	begin
		sw_d        = sw_q;
		tries_d     = tries_q;
		puk_tries_d = puk_tries_q;
		enabled_d   = enabled_q;
		verified_d  = verified_q;
		alt_key_d   = alt_key_q;
		ref_d       = ref_q;
		unique case (op)
			pg_pkg::CMD_VERIFY:
				if (blocked)
					sw_d = '{pg_pkg::SW1_REFUSE, pg_pkg::SW2_BLOCKED};
				else if (empty)
					sw_d = '{pg_pkg::SW1_RETRY, {pg_pkg::SW2_RETRY_H, tries_q}};
				else if (match)
				begin
					sw_d       = '{pg_pkg::SW1_OK, pg_pkg::SW2_OK};
					tries_d    = pg_pkg::PIN_TRIES_INIT;
					verified_d = 1'b1;
				end
				else
				begin
					tries_d = tries_q - 4'h1;
					sw_d    = '{pg_pkg::SW1_RETRY, {pg_pkg::SW2_RETRY_H, tries_q - 4'h1}};
				end
			pg_pkg::CMD_DISABLE:
				if (blocked)
					sw_d = '{pg_pkg::SW1_REFUSE, pg_pkg::SW2_BLOCKED};
				else if (!enabled_q)
					sw_d = '{pg_pkg::SW1_REFUSE, pg_pkg::SW2_NOTALLOW};
				else if (match)
				begin
					sw_d      = '{pg_pkg::SW1_OK, pg_pkg::SW2_OK};
					tries_d   = pg_pkg::PIN_TRIES_INIT;
					enabled_d = 1'b0;
					alt_key_d = cmd_q[pg_pkg::CMD_ALT_BIT];
				end
				else
				begin
					tries_d = tries_q - 4'h1;
					sw_d    = '{pg_pkg::SW1_RETRY, {pg_pkg::SW2_RETRY_H, tries_q - 4'h1}};
				end
			pg_pkg::CMD_ENABLE:
				if (blocked)
					sw_d = '{pg_pkg::SW1_REFUSE, pg_pkg::SW2_BLOCKED};
				else if (enabled_q)
					sw_d = '{pg_pkg::SW1_REFUSE, pg_pkg::SW2_NOTALLOW};
				else if (match)
				begin
					sw_d       = '{pg_pkg::SW1_OK, pg_pkg::SW2_OK};
					tries_d    = pg_pkg::PIN_TRIES_INIT;
					enabled_d  = 1'b1;
					verified_d = 1'b0;
					alt_key_d  = 1'b0;
				end
				else
				begin
					tries_d = tries_q - 4'h1;
					sw_d    = '{pg_pkg::SW1_RETRY, {pg_pkg::SW2_RETRY_H, tries_q - 4'h1}};
				end
			pg_pkg::CMD_UNBLOCK:
				if (empty)
					sw_d = '{pg_pkg::SW1_RETRY, {pg_pkg::SW2_RETRY_H, puk_tries_q}};
				else if (puk_blocked)
					sw_d = '{pg_pkg::SW1_REFUSE, pg_pkg::SW2_BLOCKED};
				else if (puk_match)
				begin
					sw_d        = '{pg_pkg::SW1_OK, pg_pkg::SW2_OK};
					tries_d     = pg_pkg::PIN_TRIES_INIT;
					puk_tries_d = pg_pkg::PUK_TRIES_INIT;
					enabled_d   = 1'b1;
					verified_d  = 1'b1;
				end
				else
				begin
					puk_tries_d = puk_tries_q - 4'h1;
					sw_d = '{pg_pkg::SW1_RETRY, {pg_pkg::SW2_RETRY_H, puk_tries_q - 4'h1}};
				end
			pg_pkg::CMD_READ:
				if (cmd_q[pg_pkg::CMD_PROT_BIT] && !access_granted)
					sw_d = '{pg_pkg::SW1_REFUSE, pg_pkg::SW2_DENIED};
				else
					sw_d = '{pg_pkg::SW1_OK, pg_pkg::SW2_OK};
			pg_pkg::CMD_RESET:
			begin
				// card reset drops only the session's verification
				verified_d = 1'b0;
				sw_d       = '{pg_pkg::SW1_OK, pg_pkg::SW2_OK};
			end
			default:
				sw_d = '{pg_pkg::SW1_REFUSE, pg_pkg::SW2_NOTALLOW};
		endcase
	end

	// persistent security state, touched by command completion and, for ref_q, also by an idle write to the ref register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sw_q        <= '{pg_pkg::SW1_OK, pg_pkg::SW2_OK};
			tries_q     <= pg_pkg::PIN_TRIES_INIT;
			puk_tries_q <= pg_pkg::PUK_TRIES_INIT;
			enabled_q   <= 1'b1;
			verified_q  <= 1'b0;
			alt_key_q   <= 1'b0;
			ref_q       <= pg_pkg::PIN_RESET_VAL;
		end
		else if (state_q == PG_EXEC)
		begin
			sw_q        <= sw_d;
			tries_q     <= tries_d;
			puk_tries_q <= puk_tries_d;
			enabled_q   <= enabled_d;
			verified_q  <= verified_d;
			alt_key_q   <= alt_key_d;
			ref_q       <= ref_d;
		end
		else if (wr && paddr == pg_pkg::OFF_REF && !busy_q)
			ref_q <= pwdata;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			puk_q <= pg_pkg::PUK_RESET_VAL;
		else if (wr && paddr == pg_pkg::OFF_PUK && !busy_q)
			puk_q <= pwdata;
	end

	// read data
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			unique case (paddr)
				pg_pkg::OFF_CMD:    prdata <= cmd_q;
				pg_pkg::OFF_STATUS: prdata <= {20'h0, alt_key_q, puk_blocked, busy_q,
					access_granted, verified_q, blocked, enabled_q, 1'b0, tries_q};
				pg_pkg::OFF_SW:     prdata <= {16'h0, sw_q.sw1, sw_q.sw2};
				pg_pkg::OFF_TLV:    prdata <= {pg_pkg::TAG_FCP, pg_pkg::TAG_PS,
					pg_pkg::TAG_USAGE,
					enabled_q ? pg_pkg::PS_ENABLED : pg_pkg::PS_DISABLED};
				pg_pkg::OFF_ALTK:   prdata <= {28'h0, puk_tries_q};
				default:            prdata <= 32'h0000_0000;
			endcase
	end

	// checks
	sequence s_cmd_taken;
		start;
	endsequence
	sequence s_exec_done;
		state_q == PG_EXEC ##1 state_q == PG_DONE && busy_q ##1 state_q == PG_IDLE && !busy_q;
	endsequence
	// a wrong pin given to a command that compares it
	sequence s_wrong_try;
		state_q == PG_EXEC && !blocked && !match
		&& ((op == pg_pkg::CMD_VERIFY && !empty) || (op == pg_pkg::CMD_DISABLE && enabled_q)
		|| (op == pg_pkg::CMD_ENABLE && !enabled_q));
	endsequence
	a_cmd_walk: assert property (@(posedge pclk) disable iff (!presetn)
		s_cmd_taken |=> s_exec_done)
		else $error("command sequence broken");
	a_refuse_read: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == PG_EXEC && op == pg_pkg::CMD_READ && cmd_q[pg_pkg::CMD_PROT_BIT]
		&& enabled_q && !verified_q
		|=> sw_q.sw1 == pg_pkg::SW1_REFUSE && sw_q.sw2 == pg_pkg::SW2_DENIED)
		else $error("protected read not refused");
	a_dis_wrong: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == PG_EXEC && op == pg_pkg::CMD_DISABLE && enabled_q && !blocked && !match
		|=> enabled_q && sw_q.sw1 == pg_pkg::SW1_RETRY
		&& sw_q.sw2 == {pg_pkg::SW2_RETRY_H, tries_q})
		else $error("wrong disable mishandled");
	a_tlv_enabled: assert property (@(posedge pclk) disable iff (!presetn)
		rd && paddr == pg_pkg::OFF_TLV
		|-> prdata[7:0] == ($past(enabled_q) ? pg_pkg::PS_ENABLED : pg_pkg::PS_DISABLED))
		else $error("status object value wrong");
	a_empty_verify: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == PG_EXEC && op == pg_pkg::CMD_VERIFY && empty && !blocked
		|=> sw_q.sw1 == pg_pkg::SW1_RETRY && sw_q.sw2[3:0] == $past(tries_q)
		&& $stable(tries_q))
		else $error("empty verify changed state");
	a_disable_ok: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == PG_EXEC && op == pg_pkg::CMD_DISABLE && enabled_q && !blocked && match
		|=> !enabled_q && tries_q == pg_pkg::PIN_TRIES_INIT && sw_q.sw1 == pg_pkg::SW1_OK)
		else $error("disable did not complete");
	a_cnt_persist: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == PG_EXEC && op == pg_pkg::CMD_RESET
		|=> $stable(tries_q) && $stable(enabled_q) && !verified_q)
		else $error("card reset touched persistent state");
	a_block_refuse: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == PG_EXEC && blocked && (op == pg_pkg::CMD_VERIFY || op == pg_pkg::CMD_DISABLE)
		|=> sw_q.sw1 == pg_pkg::SW1_REFUSE && sw_q.sw2 == pg_pkg::SW2_BLOCKED)
		else $error("blocked pin not refused");
	a_unblock_cnt: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == PG_EXEC && op == pg_pkg::CMD_UNBLOCK && !empty && !puk_blocked && puk_match
		|=> tries_q == pg_pkg::PIN_TRIES_INIT && puk_tries_q == pg_pkg::PUK_TRIES_INIT)
		else $error("unblock counters not restored");
	a_dis_twice: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == PG_EXEC && op == pg_pkg::CMD_DISABLE && !enabled_q && !blocked
		|=> sw_q.sw1 == pg_pkg::SW1_REFUSE && !enabled_q && $stable(tries_q))
		else $error("disable of disabled pin executed");
	a_enable_ok: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == PG_EXEC && op == pg_pkg::CMD_ENABLE && !enabled_q && !blocked && match
		|=> enabled_q && tries_q == pg_pkg::PIN_TRIES_INIT && !alt_key_q)
		else $error("enable did not complete");
	a_enable_refuse: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == PG_EXEC && op == pg_pkg::CMD_ENABLE && (enabled_q || blocked)
		|=> sw_q.sw1 == pg_pkg::SW1_REFUSE && $stable(tries_q) && $stable(enabled_q))
		else $error("refused enable executed");
	a_enable_wrong: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == PG_EXEC && op == pg_pkg::CMD_ENABLE && !enabled_q && !blocked && !match
		|=> !enabled_q && tries_q == $past(tries_q) - 4'h1)
		else $error("wrong enable mishandled");
	a_wrong_dec: assert property (@(posedge pclk) disable iff (!presetn)
		s_wrong_try |=> tries_q == $past(tries_q) - 4'h1)
		else $error("wrong pin did not count down");
	a_block_third: assert property (@(posedge pclk) disable iff (!presetn)
		s_wrong_try ##0 tries_q == 4'h1
		|=> blocked && sw_q.sw2 == {pg_pkg::SW2_RETRY_H, 4'h0})
		else $error("last wrong pin did not block");
	a_read_blocked: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == PG_EXEC && op == pg_pkg::CMD_READ && cmd_q[pg_pkg::CMD_PROT_BIT]
		&& blocked && enabled_q
		|=> sw_q.sw1 == pg_pkg::SW1_REFUSE && sw_q.sw2 == pg_pkg::SW2_DENIED)
		else $error("blocked enabled pin granted access");
	a_blocked_dis: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == PG_EXEC && op == pg_pkg::CMD_READ && blocked && !enabled_q
		|=> sw_q.sw1 == pg_pkg::SW1_OK && sw_q.sw2 == pg_pkg::SW2_OK)
		else $error("blocked disabled pin denied access");
	a_unblock_wrong: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == PG_EXEC && op == pg_pkg::CMD_UNBLOCK && !empty && !puk_blocked && !puk_match
		|=> puk_tries_q == $past(puk_tries_q) - 4'h1 && $stable(tries_q) && $stable(enabled_q))
		else $error("wrong unblock key mishandled");
	a_puk_refuse: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == PG_EXEC && op == pg_pkg::CMD_UNBLOCK && !empty && puk_blocked
		|=> sw_q.sw1 == pg_pkg::SW1_REFUSE && sw_q.sw2 == pg_pkg::SW2_BLOCKED
		&& $stable(tries_q))
		else $error("blocked unblock key not refused");
endmodule // pg_guard
`default_nettype wire

// *** tb/pg_terminal.sv ***
// terminal model: apb master that issues card commands
`default_nettype none
module pg_terminal
(
	// clock
	input  wire logic        pclk,
	// apb master
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready
);
	timeunit 1ns;
	timeprecision 1ps;
	// set once any transfer runs out of its wait bound
	bit          hung;
	initial
	begin
		hung = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end
	// one transfer, entered just after a rising edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1)
			hung = 1'b1;
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
		@(posedge pclk);
	endtask
	// pin first, then command, then wait for idle and fetch the status word
	task automatic cmd(input logic [10:0] c, input logic [31:0] pin,
		output logic [31:0] sw, output bit ok);
		logic [31:0] r;
		int          n;
		xfer(1'b1, pg_pkg::OFF_PIN, pin, r);
		xfer(1'b1, pg_pkg::OFF_CMD, {21'h000000, c}, r);
		n = 0;
		r = 32'h0000_0200;
		while (r[9] !== 1'b0 && n < 20)
		begin
			xfer(1'b0, pg_pkg::OFF_STATUS, 32'h0000_0000, r);
			n++;
		end
		xfer(1'b0, pg_pkg::OFF_SW, 32'h0000_0000, sw);
		ok = (r[9] === 1'b0) && !hung;
	endtask
endmodule // pg_terminal
`default_nettype wire

// *** tb/tb.sv ***
// testbench: pin guard command flows over apb
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [10:0] VFY_E = 11'h101, VFY = 11'h001, RD_P = 11'h205;
	localparam logic [10:0] DIS = 11'h002, DIS_A = 11'h402, ENA = 11'h003;
	localparam logic [10:0] UNB = 11'h004, CRST = 11'h006;
	localparam logic [15:0] OK = {pg_pkg::SW1_OK, pg_pkg::SW2_OK};
	localparam logic [15:0] DEN = {pg_pkg::SW1_REFUSE, pg_pkg::SW2_DENIED};
	localparam logic [15:0] BLK = {pg_pkg::SW1_REFUSE, pg_pkg::SW2_BLOCKED};
	localparam logic [15:0] NAL = {pg_pkg::SW1_REFUSE, pg_pkg::SW2_NOTALLOW};
	localparam logic [31:0] PUK = pg_pkg::PUK_RESET_VAL;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        pin_enabled, pin_blocked, access_granted;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	int          err_total, checks_done;
	initial pclk = 1'b0;
	always #5 pclk = ~pclk;
	pg_guard uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pin_enabled(pin_enabled),
		.pin_blocked(pin_blocked), .access_granted(access_granted));
	pg_terminal term (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready));
	function automatic logic [15:0] rc(input logic [3:0] n);
		return {pg_pkg::SW1_RETRY, pg_pkg::SW2_RETRY_H, n};
	endfunction
	task automatic test_done;
		if (err_total == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic go(input logic [10:0] c, input logic [31:0] pin, output logic [31:0] sw);
		bit ok;
		term.cmd(c, pin, sw, ok);
		`CHK("command done", 1'b1, ok)
		if (!ok)
			test_done();
	endtask
	task automatic sw_is(input logic [10:0] c, input logic [31:0] pin, input logic [15:0] e);
		logic [31:0] sw;
		go(c, pin, sw);
		`CHK("status word", {16'h0000, e}, sw)
	endtask
	task automatic reg_is(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] r;
		term.xfer(1'b0, a, 32'h0000_0000, r);
		`CHK("transfer done", 1'b0, term.hung)
		if (term.hung)
			test_done();
		`CHK("register", e, r & m)
	endtask
	task automatic s_disable;
		logic [31:0] sw;
		reg_is(pg_pkg::OFF_STATUS, 32'h0000_006F, 32'h0000_0023);
		sw_is(RD_P, 32'h0, DEN);
		sw_is(DIS, 32'h1, rc(4'h2));
		sw_is(RD_P, 32'h0, DEN);
		reg_is(pg_pkg::OFF_TLV, 32'hFFFF_FFFF, 32'h62C6_9080);
		sw_is(VFY_E, 32'h0, rc(4'h2));
		sw_is(VFY_E, 32'h0, rc(4'h2));
		sw_is(DIS, 32'h0, OK);
		reg_is(pg_pkg::OFF_TLV, 32'hFFFF_FFFF, 32'h62C6_9000);
		sw_is(VFY_E, 32'h0, rc(4'h3));
		go(CRST, 32'h0, sw);
		sw_is(RD_P, 32'h0, OK);
		sw_is(DIS, 32'h0, NAL);
		sw_is(ENA, 32'h1, rc(4'h2));
		`CHK("enabled", 1'b0, pin_enabled)
		sw_is(RD_P, 32'h0, OK);
	endtask
	task automatic s_enable;
		logic [31:0] sw;
		sw_is(ENA, 32'h0, OK);
		`CHK("enabled", 1'b1, pin_enabled)
		sw_is(VFY_E, 32'h0, rc(4'h3));
		sw_is(RD_P, 32'h0, DEN);
		sw_is(ENA, 32'h0, NAL);
		sw_is(VFY, 32'h0, OK);
		sw_is(RD_P, 32'h0, OK);
		go(CRST, 32'h0, sw);
	endtask
	task automatic s_block;
		logic [31:0] sw;
		sw_is(DIS, 32'h1, rc(4'h2));
		sw_is(DIS, 32'h1, rc(4'h1));
		go(CRST, 32'h0, sw);
		sw_is(DIS, 32'h1, rc(4'h0));
		`CHK("blocked", 1'b1, pin_blocked)
		sw_is(VFY, 32'h0, BLK);
		sw_is(DIS, 32'h0, BLK);
		sw_is(ENA, 32'h0, BLK);
		sw_is(RD_P, 32'h0, DEN);
		`CHK("granted", 1'b0, access_granted)
		sw_is(UNB, 32'h1, rc(4'h9));
		sw_is(UNB, PUK, OK);
		sw_is(RD_P, 32'h0, OK);
		sw_is(VFY_E, 32'h0, rc(4'h3));
		sw_is(UNB, 32'h1, rc(4'h9));
		sw_is(UNB, PUK, OK);
		reg_is(pg_pkg::OFF_ALTK, 32'h0000_000F, 32'h0000_000A);
		for (int i = 9; i >= 0; i--)
			sw_is(UNB, 32'h1, rc(i[3:0]));
		sw_is(UNB, PUK, BLK);
	endtask
	task automatic s_alt_dis_block;
		sw_is(DIS_A, 32'h0, OK);
		reg_is(pg_pkg::OFF_STATUS, 32'h0000_0800, 32'h0000_0800);
		sw_is(ENA, 32'h0, OK);
		reg_is(pg_pkg::OFF_STATUS, 32'h0000_0800, 32'h0000_0000);
		sw_is(DIS, 32'h0, OK);
		sw_is(ENA, 32'h1, rc(4'h2));
		sw_is(ENA, 32'h1, rc(4'h1));
		sw_is(ENA, 32'h1, rc(4'h0));
		reg_is(pg_pkg::OFF_STATUS, 32'h0000_006F, 32'h0000_0040);
		sw_is(RD_P, 32'h0, OK);
		`CHK("granted", 1'b1, access_granted)
		`CHK("slave error", 1'b0, pslverr)
		reg_is(8'h20, 32'hFFFF_FFFF, 32'h0000_0000);
	endtask
	initial
	begin
		presetn = 1'b0;
		err_total = 0;
		checks_done = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		s_disable();
		s_enable();
		s_block();
		s_alt_dis_block();
		test_done();
	end
endmodule // tb
`default_nettype wire
